// ==== clkgen_ctrl_bank.sv ====
// Functional notes
// - Write frame opens with start and address D2, which the bank acknowledges.
// - After address, index byte then count byte, each acknowledged.
// - Count data bytes fill registers upward from index, each acknowledged, stop ends.
// - Read: write index, repeated start, address D3 acknowledged.
// - After read address, send byte count first, then registers from index up.
// - Register 0 bit 7 turns the CPU/SRC PLL on; resets to one.
// - Bits 6 and 5 turn DOT and LCD PLLs on; reset one; bit 4 reserved.
// - Bits 3 and 2 are CPU/SRC divider enables, cleared when bit 7 written zero.
// - Bit 1 LCD divider clears with bit 5; bit 0 DOT divider clears with bit 6.
// - Register 1 bit 7 enables fixed down-spread on CPU/SRC PLL; resets on.
// - Bit 6 enables LCD spread, bits 5..3 pick setting, bits 2..0 reserved.
// - Spread code: 0..3 down-spread amounts, 4..7 centre-spread amounts.
// - Register 2 bits enable the eight differential output buffers; reset one.
// - Register 3 bit 5 enables the reference buffer; bits 7 and 6 reserved.
// - Bits 4..3 set reference edge rate; reset value is fast.
// - Bits 2..0 make CPU outputs 0..2 stoppable; reset to free-running.
// - Stoppable enabled CPU pair parks true high, complement low on stop.
// - Reference runs only when enabled and not powered down, else low.
// - Register 4 bit 0 holds CPU multiplier bit 8; other bits reserved.
// - CPU clock is four MHz times N over P.
`default_nettype none
`include "clkgen_consts.svh"
module clkgen_ctrl_bank
    import clkgen_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic reset_n, // Async reset, low
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value
    output logic sda_oe, // Serial data drive enable
    input wire logic cpu_stop_request_n, // CPU stop pin, low
    input wire logic power_down, // Power-down pin, high
    output logic cpu_src_pll_on, // CPU/SRC PLL enable
    output logic video_dot_pll_on, // DOT PLL enable
    output logic panel_pll_on, // LCD PLL enable
    output logic cpu_div_on, // CPU divider enable
    output logic src_div_on, // SRC divider enable
    output logic panel_div_on, // LCD divider enable
    output logic dot_div_on, // DOT divider enable
    output logic cpu_src_spread_on, // CPU/SRC spread enable
    output logic panel_spread_on, // LCD spread enable
    output logic [2:0] panel_spread_code, // LCD spread setting
    output logic [7:0] buffer_on, // Output buffer enables
    output logic ref_on, // Reference buffer enable
    output logic [1:0] ref_slew, // Reference edge rate
    output logic cpu_out0_stoppable, // CPU0 stoppable
    output logic cpu_out1_stoppable, // CPU1 stoppable
    output logic cpu_out2_stoppable, // CPU2 stoppable
    output logic cpu_multiplier_bit8, // CPU multiplier bit 8
    output logic [2:0] cpu_out_run, // CPU pair running
    output logic [2:0] cpu_out_park, // CPU pair parked high
    output logic ref_run // Reference running
);

    clkgen_bank_t q;
    clkgen_bank_t d;

    logic [3:0] pins;
    logic scl_s;
    logic sda_s;
    logic stop_n_s;
    logic pd_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rd_byte;

    // Pin synchronisers
    clkgen_sync u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({power_down, cpu_stop_request_n, sda_in, scl_in}),
        .sync_out(pins)
    );

    assign scl_s = pins[0];
    assign sda_s = pins[1];
    assign stop_n_s = pins[2];
    assign pd_s = pins[3];

    // Bus events from synchronised levels
    assign scl_rise = scl_s & ~q.scl_prev;
    assign scl_fall = ~scl_s & q.scl_prev;
    assign start_seen = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
    assign stop_seen = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

    // Register read, unmapped indices return zero
    assign rd_byte = (q.index < 8'(`CLKGEN_NUM_REGS)) ? q.regs[q.index[2:0]] : 8'h00;

    // Merge written byte with reserved bits and apply divider auto-clear
    function automatic logic [7:0] wr_merge(input logic [2:0] idx, input logic [7:0] wd,
                                            input logic [7:0] old);
        logic [7:0] m;
        logic [7:0] r;
        m = 8'h00;
        r = wd;
        case (idx)
            3'h0: begin
                m = `CLKGEN_WMASK_PLL_DIV;
                if (!wd[`CLKGEN_B_CPU_PLL]) begin
                    r[`CLKGEN_B_CPU_DIV] = 1'b0;
                    r[`CLKGEN_B_SRC_DIV] = 1'b0;
                end
                if (!wd[`CLKGEN_B_LCD_PLL]) begin
                    r[`CLKGEN_B_LCD_DIV] = 1'b0;
                end
                if (!wd[`CLKGEN_B_DOT_PLL]) begin
                    r[`CLKGEN_B_DOT_DIV] = 1'b0;
                end
            end
            3'h1: begin
                m = `CLKGEN_WMASK_SPREAD;
            end
            3'h2: begin
                m = `CLKGEN_WMASK_BUF_EN;
            end
            3'h3: begin
                m = `CLKGEN_WMASK_OUT_CTL;
            end
            3'h4: begin
                m = `CLKGEN_WMASK_MULT_HI;
            end
            default: begin
                m = 8'h00;
            end
        endcase
        // Reserved bits keep their reset value
        wr_merge = (r & m) | (old & ~m);
    endfunction

    // Serial engine, register bank and output gating
    always_comb begin
        d = q;
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;
        d.sda_out = 1'b0;

        case (q.state)
            CLKGEN_IDLE: begin
                d.sda_oe = 1'b0;
            end

            // Shift in eight bits, then answer on the falling edge
            CLKGEN_RX: begin
                if (scl_rise && q.bit_cnt != 4'h8) begin
                    d.shreg = {q.shreg[6:0], sda_s};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall && q.bit_cnt == 4'h8) begin
                    d.bit_cnt = 4'h0;
                    d.state = CLKGEN_RX_ACK;
                    d.sda_oe = 1'b1;
                    case (q.phase)
                        CLKGEN_PH_ADDR: begin
                            if (q.shreg == `CLKGEN_ADDR_WRITE) begin
                                d.phase = CLKGEN_PH_INDEX;
                            end else if (q.shreg == `CLKGEN_ADDR_READ) begin
                                d.first_tx = 1'b1;
                            end else begin
                                d.sda_oe = 1'b0;
                                d.state = CLKGEN_WAIT;
                            end
                        end
                        CLKGEN_PH_INDEX: begin
                            d.index = q.shreg;
                            d.phase = CLKGEN_PH_COUNT;
                        end
                        CLKGEN_PH_COUNT: begin
                            d.remain = q.shreg;
                            d.phase = CLKGEN_PH_DATA;
                        end
                        CLKGEN_PH_DATA: begin
                            // Bytes past the count are acknowledged and dropped
                            if (q.remain != 8'h00) begin
                                d.remain = q.remain - 8'h01;
                                d.index = q.index + 8'h01;
                                if (q.index < 8'(`CLKGEN_NUM_REGS)) begin
                                    d.regs[q.index[2:0]] = wr_merge(q.index[2:0], q.shreg,
                                                                    q.regs[q.index[2:0]]);
                                end
                            end
                        end
                        default: begin
                            d.state = CLKGEN_WAIT;
                        end
                    endcase
                end
            end

            // Hold the acknowledge low for one clock pulse
            CLKGEN_RX_ACK: begin
                if (scl_fall) begin
                    if (q.first_tx) begin
                        d.first_tx = 1'b0;
                        d.shreg = `CLKGEN_READ_COUNT;
                        d.sda_oe = ~d.shreg[7];
                        d.bit_cnt = 4'h0;
                        d.state = CLKGEN_TX;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.state = CLKGEN_RX;
                    end
                end
            end

            // Drive one bit per falling edge, msb first
            CLKGEN_TX: begin
                if (scl_fall) begin
                    if (q.bit_cnt == 4'h7) begin
                        d.sda_oe = 1'b0;
                        d.state = CLKGEN_TX_ACK;
                    end else begin
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.sda_oe = ~q.shreg[6];
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                end
            end

            // Host answer: ack asks for the next byte, nack ends the read
            CLKGEN_TX_ACK: begin
                if (scl_rise) begin
                    d.host_ack = ~sda_s;
                end
                if (scl_fall) begin
                    if (q.host_ack) begin
                        d.shreg = rd_byte;
                        d.sda_oe = ~rd_byte[7];
                        d.index = q.index + 8'h01;
                        d.bit_cnt = 4'h0;
                        d.state = CLKGEN_TX;
                    end else begin
                        d.state = CLKGEN_WAIT;
                    end
                end
            end

            // Not addressed or finished: stay off the bus
            CLKGEN_WAIT: begin
                d.sda_oe = 1'b0;
            end

            default: begin
                d.sda_oe = 1'b0;
                d.state = CLKGEN_IDLE;
            end
        endcase

        // Start or repeated start always reopens address reception
        if (start_seen) begin
            d.state = CLKGEN_RX;
            d.phase = CLKGEN_PH_ADDR;
            d.bit_cnt = 4'h0;
            d.first_tx = 1'b0;
            d.sda_oe = 1'b0;
        end else if (stop_seen) begin
            d.state = CLKGEN_IDLE;
            d.sda_oe = 1'b0;
        end

        // Per CPU pair: off, parked or running
        for (int i = 0; i < 3; i++) begin
            d.cpu_run[i] = 1'b0;
            d.cpu_park[i] = 1'b0;
            if (!pd_s && q.regs[2][`CLKGEN_B_CPU0_BUF - i]) begin
                if (q.regs[3][2 - i] && !stop_n_s) begin
                    d.cpu_park[i] = 1'b1;
                end else begin
                    d.cpu_run[i] = 1'b1;
                end
            end
        end

        // Reference runs only when enabled and powered
        d.ref_run = ~pd_s & q.regs[3][`CLKGEN_B_REF_EN];
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q.state <= CLKGEN_IDLE;
            q.phase <= CLKGEN_PH_ADDR;
            q.regs[0] <= `CLKGEN_RST_PLL_DIV;
            q.regs[1] <= `CLKGEN_RST_SPREAD;
            q.regs[2] <= `CLKGEN_RST_BUF_EN;
            q.regs[3] <= `CLKGEN_RST_OUT_CTL;
            q.regs[4] <= `CLKGEN_RST_MULT_HI;
            q.shreg <= 8'h00;
            q.bit_cnt <= 4'h0;
            q.index <= 8'h00;
            q.remain <= 8'h00;
            q.first_tx <= 1'b0;
            q.host_ack <= 1'b0;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
            q.sda_out <= 1'b0;
            q.sda_oe <= 1'b0;
            q.cpu_run <= 3'h0;
            q.cpu_park <= 3'h0;
            q.ref_run <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Serial pin drive
    assign sda_out = q.sda_out;
    assign sda_oe = q.sda_oe;

    // PLL and divider enables
    assign cpu_src_pll_on = q.regs[0][`CLKGEN_B_CPU_PLL];
    assign video_dot_pll_on = q.regs[0][`CLKGEN_B_DOT_PLL];
    assign panel_pll_on = q.regs[0][`CLKGEN_B_LCD_PLL];
    assign cpu_div_on = q.regs[0][`CLKGEN_B_CPU_DIV];
    assign src_div_on = q.regs[0][`CLKGEN_B_SRC_DIV];
    assign panel_div_on = q.regs[0][`CLKGEN_B_LCD_DIV];
    assign dot_div_on = q.regs[0][`CLKGEN_B_DOT_DIV];

    // Spread controls; code values follow clkgen_spread_code_t
    assign cpu_src_spread_on = q.regs[1][`CLKGEN_B_CPU_SS];
    assign panel_spread_on = q.regs[1][`CLKGEN_B_LCD_SS];
    assign panel_spread_code =
        q.regs[1][`CLKGEN_B_SS_CODE_HI:`CLKGEN_B_SS_CODE_LO];

    // Buffers and reference control
    assign buffer_on = q.regs[2];
    assign ref_on = q.regs[3][`CLKGEN_B_REF_EN];
    assign ref_slew = q.regs[3][`CLKGEN_B_SLEW_HI:`CLKGEN_B_SLEW_LO];
    assign cpu_out0_stoppable = q.regs[3][2];
    assign cpu_out1_stoppable = q.regs[3][1];
    assign cpu_out2_stoppable = q.regs[3][0];

    // Top multiplier bit; Fcpu = CLKGEN_FREF_MHZ x N / P downstream
    assign cpu_multiplier_bit8 = q.regs[4][`CLKGEN_B_MULT8];

    // Gated output states
    assign cpu_out_run = q.cpu_run;
    assign cpu_out_park = q.cpu_park;
    assign ref_run = q.ref_run;

endmodule // clkgen_ctrl_bank
`default_nettype wire

// ==== clkgen_consts.svh ====
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH

// Bus addresses, write and read form
`define CLKGEN_ADDR_WRITE 8'hD2
`define CLKGEN_ADDR_READ 8'hD3

// Register indices
`define CLKGEN_IDX_PLL_DIV 8'h00
`define CLKGEN_IDX_SPREAD 8'h01
`define CLKGEN_IDX_BUF_EN 8'h02
`define CLKGEN_IDX_OUT_CTL 8'h03
`define CLKGEN_IDX_MULT_HI 8'h04
`define CLKGEN_NUM_REGS 5

// Reset values
`define CLKGEN_RST_PLL_DIV 8'hEF
`define CLKGEN_RST_SPREAD 8'hC0
`define CLKGEN_RST_BUF_EN 8'hFF
`define CLKGEN_RST_OUT_CTL 8'h30
`define CLKGEN_RST_MULT_HI 8'hFE

// Writable bit masks, reserved bits stay at reset value
`define CLKGEN_WMASK_PLL_DIV 8'hEF
`define CLKGEN_WMASK_SPREAD 8'hF8
`define CLKGEN_WMASK_BUF_EN 8'hFF
`define CLKGEN_WMASK_OUT_CTL 8'h3F
`define CLKGEN_WMASK_MULT_HI 8'h01

// Field positions, register 0
`define CLKGEN_B_CPU_PLL 7
`define CLKGEN_B_DOT_PLL 6
`define CLKGEN_B_LCD_PLL 5
`define CLKGEN_B_CPU_DIV 3
`define CLKGEN_B_SRC_DIV 2
`define CLKGEN_B_LCD_DIV 1
`define CLKGEN_B_DOT_DIV 0
// Register 1
`define CLKGEN_B_CPU_SS 7
`define CLKGEN_B_LCD_SS 6
`define CLKGEN_B_SS_CODE_HI 5
`define CLKGEN_B_SS_CODE_LO 3
// Register 3
`define CLKGEN_B_REF_EN 5
`define CLKGEN_B_SLEW_HI 4
`define CLKGEN_B_SLEW_LO 3
// Register 4
`define CLKGEN_B_MULT8 0
// Register 2: CPU buffer enables start at bit 7 and go down
`define CLKGEN_B_CPU0_BUF 7

// Byte count returned ahead of read data
`define CLKGEN_READ_COUNT 8'h05

// CPU clock programming: Fcpu = 4 MHz x N / P
`define CLKGEN_FREF_MHZ 4
`define CLKGEN_N_DEFAULT 9'h064
`define CLKGEN_N_166 9'h07D

`endif

// ==== clkgen_pkg.sv ====
`default_nettype none
package clkgen_pkg;

    // Serial engine states, one-hot
    typedef enum logic [5:0] {
        CLKGEN_IDLE = 6'h01,
        CLKGEN_RX = 6'h02,
        CLKGEN_RX_ACK = 6'h04,
        CLKGEN_TX = 6'h08,
        CLKGEN_TX_ACK = 6'h10,
        CLKGEN_WAIT = 6'h20
    } clkgen_state_t;

    // Which byte of the frame is being received
    typedef enum logic [1:0] {
        CLKGEN_PH_ADDR = 2'h0,
        CLKGEN_PH_INDEX = 2'h1,
        CLKGEN_PH_COUNT = 2'h2,
        CLKGEN_PH_DATA = 2'h3
    } clkgen_phase_t;

    // LCD spread codes
    typedef enum logic [2:0] {
        CLKGEN_SS_DN_0P5 = 3'h0,
        CLKGEN_SS_DN_1P0 = 3'h1,
        CLKGEN_SS_DN_2P0 = 3'h2,
        CLKGEN_SS_DN_2P5 = 3'h3,
        CLKGEN_SS_CT_0P25 = 3'h4,
        CLKGEN_SS_CT_0P5 = 3'h5,
        CLKGEN_SS_CT_1P0 = 3'h6,
        CLKGEN_SS_CT_1P25 = 3'h7
    } clkgen_spread_code_t;

    // Synchroniser state
    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
    } clkgen_sync_t;

    // Whole state of the control bank
    typedef struct packed {
        clkgen_state_t state;
        clkgen_phase_t phase;
        logic [4:0][7:0] regs;
        logic [7:0] shreg;
        logic [3:0] bit_cnt;
        logic [7:0] index;
        logic [7:0] remain;
        logic first_tx;
        logic host_ack;
        logic scl_prev;
        logic sda_prev;
        logic sda_out;
        logic sda_oe;
        logic [2:0] cpu_run;
        logic [2:0] cpu_park;
        logic ref_run;
    } clkgen_bank_t;

endpackage
`default_nettype wire

// ==== clkgen_sync.sv ====
`default_nettype none
module clkgen_sync
    import clkgen_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic reset_n, // Async reset
    input wire logic [3:0] async_in, // Pin levels
    output logic [3:0] sync_out // Synchronised levels
);

    clkgen_sync_t s_q;
    clkgen_sync_t s_d;

    // Two stages per bit, first stage feeds only the second
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < 4; i++) begin
            s_d.meta[i] = async_in[i];
            s_d.sync[i] = s_q.meta[i];
        end
    end

    // Idle level of every input but power_down is high; all stages reset high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{meta: 4'hF, sync: 4'hF};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;

endmodule // clkgen_sync
`default_nettype wire

// ==== clkgen_ctrl_bank_sva.sv ====
`default_nettype none
module clkgen_ctrl_bank_sva (
    input wire logic core_clk, // Clock
    input wire logic reset_n, // Reset, low
    input wire logic scl_in, // Serial clock
    input wire logic sda_oe, // Data pull-down
    input wire logic cpu_stop_request_n, // Stop pin
    input wire logic power_down, // Power-down pin
    input wire logic cpu_src_pll_on, // PLL on
    input wire logic video_dot_pll_on, // PLL on
    input wire logic panel_pll_on, // PLL on
    input wire logic cpu_div_on, // Divider on
    input wire logic src_div_on, // Divider on
    input wire logic panel_div_on, // Divider on
    input wire logic dot_div_on, // Divider on
    input wire logic [7:0] buffer_on, // Buffer enables
    input wire logic ref_on, // Reference enable
    input wire logic cpu_out0_stoppable, // CPU0 stoppable
    input wire logic cpu_out2_stoppable, // CPU2 stoppable
    input wire logic cpu_multiplier_bit8, // Multiplier bit
    input wire logic [2:0] cpu_out_run, // Pairs running
    input wire logic [2:0] cpu_out_park, // Pairs parked
    input wire logic ref_run // Reference running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // Pins reach the clock outputs within the sync delay
    chk_ref_pd_low: assert property (power_down [*4] |-> !ref_run)
        else $error("Reference runs in power-down");
    chk_ref_running: assert property ((!power_down && ref_on) [*5] |-> ref_run)
        else $error("Reference idle while enabled");
    chk_pair_off: assert property (
        (power_down || !buffer_on[7]) [*4] |-> !cpu_out_run[0] && !cpu_out_park[0])
        else $error("Disabled pair not low");
    chk_pair_parks: assert property (
        (!power_down && buffer_on[7] && cpu_out0_stoppable && !cpu_stop_request_n) [*5]
        |-> cpu_out_park[0] && !cpu_out_run[0])
        else $error("Stoppable pair not parked");
    chk_pair_free: assert property (
        (!power_down && buffer_on[5] && !cpu_out2_stoppable) [*5]
        |-> cpu_out_run[2] && !cpu_out_park[2])
        else $error("Free pair not running");
    // Dividers cannot stay on behind a stopped PLL
    chk_cpu_div_clear: assert property (
        !cpu_src_pll_on |-> !cpu_div_on && !src_div_on)
        else $error("CPU or SRC divider on with PLL off");
    chk_lcd_div_clear: assert property (!panel_pll_on |-> !panel_div_on)
        else $error("LCD divider on with PLL off");
    chk_dot_div_clear: assert property (!video_dot_pll_on |-> !dot_div_on)
        else $error("DOT divider on with PLL off");
    // Bus drive and registers change only while the serial clock is low
    chk_ack_in_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("Data drive began with clock high");
    chk_oe_holds: assert property ($rose(scl_in) && sda_oe |=> sda_oe [*8])
        else $error("Data drive dropped in clock high");
    chk_regs_quiet: assert property (
        scl_in [*6] |-> $stable(buffer_on) && $stable(cpu_multiplier_bit8))
        else $error("Register changed with bus clock idle");
endmodule // clkgen_ctrl_bank_sva
`default_nettype wire

// ==== clkgen_host_model.sv ====
`default_nettype none
`include "clkgen_consts.svh"
module clkgen_host_model (
    output logic scl, // Serial clock, parked high
    output logic sda_drv, // Data drive, 1 releases
    input wire logic sda_line // Resolved data level
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime Q = 31.25;
    // Idle bus, both lines released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // One pulse: data moves mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #Q sda_drv = b;
        #Q scl = 1'b1;
        #Q r = sda_line;
        #Q;
    endtask
    // Start, or repeated start after a byte
    task automatic start(input logic rep);
        if (rep) begin
            scl = 1'b0;
            #Q sda_drv = 1'b1;
            #Q scl = 1'b1;
        end
        #Q sda_drv = 1'b0;
        #Q;
    endtask
    // Stop, then rest
    task automatic stop();
        scl = 1'b0;
        #Q sda_drv = 1'b0;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b1;
        #(4 * Q);
    endtask
    // Byte out MSB first, ninth bit is the answer
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Byte in, refused only when last
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
    // Indexed block write, data taken from the top byte down
    task automatic write_block(input logic [7:0] idx, input int n, input logic [63:0] d,
                               output logic ok);
        logic a;
        start(1'b0);
        send(`CLKGEN_ADDR_WRITE, ok);
        send(idx, a);
        ok &= a;
        send(8'(n), a);
        ok &= a;
        for (int i = 0; i < n; i++) begin
            send(d[63 - 8 * i -: 8], a);
            ok &= a;
        end
        stop();
    endtask
    // Indexed block read, bytes packed from the top down
    task automatic read_block(input logic [7:0] idx, input int n, output logic [63:0] q,
                              output logic ok);
        logic a;
        q = '0;
        start(1'b0);
        send(`CLKGEN_ADDR_WRITE, ok);
        send(idx, a);
        ok &= a;
        start(1'b1);
        send(`CLKGEN_ADDR_READ, a);
        ok &= a;
        for (int i = 0; i < n; i++) recv(i == n - 1, q[63 - 8 * i -: 8]);
        stop();
    endtask
endmodule // clkgen_host_model
`default_nettype wire

// ==== clkgen_ctrl_bank_test.sv ====
`default_nettype none
module clkgen_ctrl_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t: got %h expected %h", $time, a, b); end end
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cpu_stop_request_n = 1'b1;
    logic power_down = 1'b0;
    logic scl_in, host_sda, sda_out, sda_oe, ref_on, ref_run, cpu_multiplier_bit8;
    logic cpu_src_pll_on, video_dot_pll_on, panel_pll_on, cpu_div_on, src_div_on;
    logic panel_div_on, dot_div_on, cpu_src_spread_on, panel_spread_on;
    logic cpu_out0_stoppable, cpu_out1_stoppable, cpu_out2_stoppable;
    logic [2:0] panel_spread_code, cpu_out_run, cpu_out_park;
    logic [1:0] ref_slew;
    logic [7:0] buffer_on;
    int failures = 0;
    int check_count = 0;
    // Open-drain data line with pull-up
    wire logic sda_in = host_sda & ~(sda_oe & ~sda_out);
    wire logic [6:0] pll_div = {cpu_src_pll_on, video_dot_pll_on, panel_pll_on, cpu_div_on,
                                src_div_on, panel_div_on, dot_div_on};
    wire logic [6:0] pairs = {cpu_out_park, cpu_out_run, ref_run};
    always #2.5 core_clk = ~core_clk;
    clkgen_ctrl_bank uut (
        .core_clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe, .cpu_stop_request_n,
        .power_down, .cpu_src_pll_on, .video_dot_pll_on, .panel_pll_on, .cpu_div_on,
        .src_div_on, .panel_div_on, .dot_div_on, .cpu_src_spread_on, .panel_spread_on,
        .panel_spread_code, .buffer_on, .ref_on, .ref_slew, .cpu_out0_stoppable,
        .cpu_out1_stoppable, .cpu_out2_stoppable, .cpu_multiplier_bit8, .cpu_out_run,
        .cpu_out_park, .ref_run
    );
    clkgen_host_model host (.scl(scl_in), .sda_drv(host_sda), .sda_line(sda_in));
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, input int n, input logic [63:0] d);
        logic ok;
        host.write_block(idx, n, d, ok);
        `CHK(ok, 1'b1)
    endtask
    task automatic rd(input logic [7:0] idx, input int n, input logic [63:0] e);
        logic ok;
        logic [63:0] q;
        host.read_block(idx, n, q, ok);
        `CHK(ok, 1'b1)
        `CHK(q, e)
    endtask
    // Pin change just after an edge, then settle
    task automatic pins(input logic s, input logic p);
        @(posedge core_clk);
        #1;
        cpu_stop_request_n = s;
        power_down = p;
        repeat (5) @(posedge core_clk);
        #1;
    endtask
    task automatic test_reset();
        `CHK(pll_div, 7'h7F)
        `CHK({cpu_src_spread_on, panel_spread_on, panel_spread_code}, 5'h18)
        `CHK(buffer_on, 8'hFF)
        `CHK({ref_on, ref_slew}, 3'h6)
        `CHK({cpu_out0_stoppable, cpu_out1_stoppable, cpu_out2_stoppable}, 3'h0)
        `CHK(cpu_multiplier_bit8, 1'b0)
        rd(8'h00, 6, 64'h05EF_C0FF_30FE_0000);
    endtask
    // Reserved bits hold, reads run on past the last register
    task automatic test_write();
        wr(8'h01, 4, 64'hFF5A_FFFF_0000_0000);
        `CHK(buffer_on, 8'h5A)
        `CHK({ref_on, ref_slew, cpu_out0_stoppable, cpu_out1_stoppable}, 5'h1F)
        `CHK(cpu_multiplier_bit8, 1'b1)
        rd(8'h01, 6, 64'h05F8_5A3F_FF00_0000);
    endtask
    task automatic test_codes();
        for (int c = 0; c < 8; c++) begin
            wr(8'h01, 1, {2'h3, 3'(c), 59'h0});
            `CHK(panel_spread_code, 3'(c))
        end
        for (int s = 0; s < 4; s++) begin
            wr(8'h03, 1, {3'h1, 2'(s), 3'h7, 56'h0});
            `CHK(ref_slew, 2'(s))
        end
    endtask
    // Stopping a PLL drops its dividers in the same write
    task automatic test_clear();
        wr(8'h00, 1, 64'hFF00_0000_0000_0000);
        rd(8'h00, 2, 64'h05EF_0000_0000_0000);
        wr(8'h00, 1, 64'h6F00_0000_0000_0000);
        `CHK(pll_div, 7'h33)
        wr(8'h00, 1, 64'h8F00_0000_0000_0000);
        `CHK(pll_div, 7'h4C)
        rd(8'h00, 2, 64'h058C_0000_0000_0000);
    endtask
    task automatic test_addr();
        logic ack;
        host.start(1'b0);
        host.send(8'hA0, ack);
        host.stop();
        `CHK(ack, 1'b0)
    endtask
    // Buffers 5A, all stoppable, reference on
    task automatic test_pins();
        pins(1'b0, 1'b0);
        `CHK(pairs, 7'h21)
        pins(1'b1, 1'b0);
        `CHK(pairs, 7'h05)
        pins(1'b0, 1'b1);
        `CHK(pairs, 7'h00)
        wr(8'h02, 2, 64'hFF1C_0000_0000_0000);
        pins(1'b0, 1'b0);
        `CHK(pairs, 7'h1C)
        pins(1'b1, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        test_reset();
        test_write();
        test_codes();
        test_clear();
        test_addr();
        test_pins();
        finish_test();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        finish_test();
    end
endmodule // clkgen_ctrl_bank_test
bind clkgen_ctrl_bank clkgen_ctrl_bank_sva chk (
    .core_clk, .reset_n, .scl_in, .sda_oe, .cpu_stop_request_n, .power_down,
    .cpu_src_pll_on, .video_dot_pll_on, .panel_pll_on, .cpu_div_on, .src_div_on,
    .panel_div_on, .dot_div_on, .buffer_on, .ref_on, .cpu_out0_stoppable,
    .cpu_out2_stoppable, .cpu_multiplier_bit8, .cpu_out_run, .cpu_out_park, .ref_run
);
`default_nettype wire
